// ===== logic/tx_link_if.sv
/*
 * Carrier between the transmit control and the frame shifter.
 * Assumes both ends run on the same clock and clock enable.
 */
`timescale 1ns/100ps
interface tx_link_if;
    logic ce;
    logic kill;
    logic tick;
    logic load;
    logic [uart_tx_pkg::DATA_W-1:0] data;
    logic data8;
    logic [uart_tx_pkg::PAR_W-1:0] parity;
    logic two_stop;
    logic ready;
    logic line;
    logic done;

    // control side drives requests and frame format
    modport ctrl (
        output ce, kill, tick, load, data, data8, parity, two_stop,
        input ready, line, done
    );

    // shifter side answers with line level and completion
    modport shift (
        input ce, kill, tick, load, data, data8, parity, two_stop,
        output ready, line, done
    );
endinterface

// ===== logic/tx_shifter.sv
/*
 * Transmit shift register and frame sequencer: start, data LSB first,
 * optional parity, one or two stop bits, one bit per baud tick.
 * Assumes the tick is a one-cycle pulse on the same clock.
 */
`timescale 1ns/100ps
module tx_shifter (
    input wire logic clk,
    input wire logic rst_n,
    tx_link_if.shift link
);
    uart_tx_pkg::frame_state_t state, next_state;
    logic [uart_tx_pkg::DATA_W-1:0] sh, next_sh;
    logic [uart_tx_pkg::CNT_W-1:0] cnt, next_cnt;
    logic stop_cnt, next_stop_cnt;
    logic par, next_par;
    logic line, next_line;
    logic done, next_done;
    logic data8, next_data8;
    logic two_stop, next_two_stop;
    logic [uart_tx_pkg::PAR_W-1:0] parity, next_parity;
    logic [uart_tx_pkg::CNT_W-1:0] last_bit;
    logic par_bit;

    // format is latched at load so a mid-frame change cannot tear a frame
    always_comb begin
        last_bit = data8 ? uart_tx_pkg::LAST_BIT_8 : uart_tx_pkg::LAST_BIT_7;
        case (parity)
            uart_tx_pkg::PARITY_ODD: par_bit = ~par;
            uart_tx_pkg::PARITY_EVEN: par_bit = par;
            default: par_bit = 1'h0;
        endcase
        link.ready = (state == uart_tx_pkg::ST_IDLE) ||
            ((state == uart_tx_pkg::ST_STOP) && (!two_stop || stop_cnt));
        link.line = line;
        link.done = done;
    end

    // next-state logic of the frame sequencer
    always_comb begin
        next_state = state;
        next_sh = sh;
        next_cnt = cnt;
        next_stop_cnt = stop_cnt;
        next_par = par;
        next_line = line;
        next_done = 1'h0;
        next_data8 = data8;
        next_two_stop = two_stop;
        next_parity = parity;
        if (link.kill) begin
            next_state = uart_tx_pkg::ST_IDLE; // RULE_03
            next_line = uart_tx_pkg::LINE_IDLE;
        end else if (link.tick) begin
            case (state)
                uart_tx_pkg::ST_DATA: begin
                    if (cnt == last_bit) begin
                        next_stop_cnt = 1'h0;
                        if (parity != uart_tx_pkg::PARITY_NONE) begin
                            next_state = uart_tx_pkg::ST_PARITY;
                            next_line = par_bit; // RULE_12
                        end else begin
                            next_state = uart_tx_pkg::ST_STOP;
                            next_line = uart_tx_pkg::STOP_LEVEL;
                            next_done = !two_stop; // RULE_01
                        end
                    end else begin
                        next_line = sh[0]; // RULE_12
                        next_sh = sh >> 1;
                        next_cnt = cnt + uart_tx_pkg::CNT_ONE;
                    end
                end
                uart_tx_pkg::ST_START: begin
                    next_state = uart_tx_pkg::ST_DATA;
                    next_line = sh[0];
                    next_sh = sh >> 1;
                    next_cnt = uart_tx_pkg::CNT_ZERO;
                end
                uart_tx_pkg::ST_PARITY: begin
                    next_state = uart_tx_pkg::ST_STOP;
                    next_line = uart_tx_pkg::STOP_LEVEL;
                    next_stop_cnt = 1'h0;
                    next_done = !two_stop; // RULE_01
                end
                uart_tx_pkg::ST_STOP, uart_tx_pkg::ST_IDLE: begin
                    if (state == uart_tx_pkg::ST_STOP && two_stop && !stop_cnt) begin
                        next_stop_cnt = 1'h1;
                        next_done = 1'h1; // RULE_01
                    end else if (link.load) begin
                        // back-to-back: start bit follows the last stop bit directly
                        next_state = uart_tx_pkg::ST_START; // RULE_04
                        next_line = uart_tx_pkg::START_LEVEL;
                        next_sh = link.data;
                        next_par = ^(link.data & (link.data8 ? uart_tx_pkg::MASK_8BIT :
                            uart_tx_pkg::MASK_7BIT));
                        next_data8 = link.data8;
                        next_parity = link.parity;
                        next_two_stop = link.two_stop;
                    end else begin
                        next_state = uart_tx_pkg::ST_IDLE; // RULE_02
                        next_line = uart_tx_pkg::LINE_IDLE;
                    end
                end
                default: begin
                    next_state = uart_tx_pkg::ST_IDLE;
                    next_line = uart_tx_pkg::LINE_IDLE;
                end
            endcase
        end
    end

    // registers only; clock enable freezes the whole sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= uart_tx_pkg::ST_IDLE;
            sh <= uart_tx_pkg::SHIFT_RESET;
            cnt <= uart_tx_pkg::CNT_ZERO;
            stop_cnt <= 1'h0;
            par <= 1'h0;
            line <= uart_tx_pkg::LINE_IDLE;
            done <= 1'h0;
            data8 <= 1'h1;
            two_stop <= 1'h0;
            parity <= uart_tx_pkg::PARITY_NONE;
        end else if (link.ce) begin
            state <= next_state;
            sh <= next_sh;
            cnt <= next_cnt;
            stop_cnt <= next_stop_cnt;
            par <= next_par;
            line <= next_line;
            done <= next_done;
            data8 <= next_data8;
            two_stop <= next_two_stop;
            parity <= next_parity;
        end
    end
endmodule // tx_shifter

// ===== logic/uart_tx_continuous_control.sv
/*
 * Transmit-side holding buffer, status flags and completion pulse of an
 * asynchronous serial channel, with the frame shifter instantiated below.
 * Assumes a baud tick and all control inputs come from logic on CLK_I.
 */
// How it works
// RULE_01 - completion pulse fires as the last stop bit starts on the line
// RULE_02 - with no byte waiting at frame end, the line stays idle
// RULE_03 - reset or disable empties the shifter without a completion pulse
// RULE_04 - buffer accepts a new byte once the previous byte starts shifting
// RULE_05 - full flag is 0 when writable, 1 while a byte waits
// RULE_06 - host writes again only after the full flag returns to 0
// RULE_07 - active flag is 1 while shifting, 0 once transmission completed
// RULE_08 - host reinitialises only after completion pulse and active flag 0
// RULE_09 - enable clears both flags; write sets full; start bit moves byte
// RULE_10 - host counts bytes and checks active flag to spot overruns
// RULE_11 - writes while transmission is disabled are dropped, no frame starts
// RULE_12 - frames carry start, data LSB first, optional parity, stop bits
// RULE_13 - completion is a one-cycle pulse; flags update on CLK_I
`timescale 1ns/100ps
module uart_tx_continuous_control (
    // clock, reset, clock enable
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // enables
    input wire logic SERIAL_UNIT_ENABLE_BIT_I,
    input wire logic TX_ENABLE_BIT_I,
    // frame format
    input wire logic DATA8_I,
    input wire logic [uart_tx_pkg::PAR_W-1:0] PARITY_MODE_I,
    input wire logic TWO_STOP_I,
    // baud tick, one cycle per bit time
    input wire logic BIT_TICK_I,
    // host write port of the transmit holding buffer
    input wire logic WR_STROBE_I,
    input wire logic [uart_tx_pkg::DATA_W-1:0] WR_DATA_I,
    // status
    output logic TX_HOLDING_FULL_FLAG_O,
    output logic TX_SHIFTER_ACTIVE_FLAG_O,
    output logic [uart_tx_pkg::DATA_W-1:0] TRANSMIT_HOLDING_BUFFER_O,
    output logic TX_DONE_IRQ_O,
    // serial line
    output logic SERIAL_OUT_PIN_O
);
    tx_link_if link ();

    logic enabled;
    logic wr_accept;
    logic load;
    logic full, next_full;
    logic active, next_active;
    logic [uart_tx_pkg::DATA_W-1:0] hold, next_hold;
    logic irq, next_irq;
    logic serial, next_serial;

    // frame sequencer and shift register
    tx_shifter shifter (
        .clk(CLK_I),
        .rst_n(RST_N_I),
        .link(link.shift)
    );

    // both enables must be set; dropping either one kills the frame at once
    always_comb begin
        enabled = SERIAL_UNIT_ENABLE_BIT_I && TX_ENABLE_BIT_I;
        wr_accept = WR_STROBE_I && enabled; // RULE_11
        // transfer only at a bit boundary, so the start bit is full length
        load = full && link.ready && BIT_TICK_I && enabled; // RULE_09
    end

    // requests and format toward the shifter
    always_comb begin
        link.ce = CE_I;
        link.kill = !enabled; // RULE_03
        link.tick = BIT_TICK_I;
        link.load = load;
        link.data = hold;
        link.data8 = DATA8_I;
        link.parity = PARITY_MODE_I;
        link.two_stop = TWO_STOP_I;
    end

    // holding buffer and its full flag
    always_comb begin
        next_hold = hold;
        next_full = full;
        if (!enabled) begin
            next_full = 1'h0; // RULE_09
        end else if (wr_accept) begin
            // a write in the load cycle wins: the new byte waits for the next frame
            next_hold = WR_DATA_I;
            next_full = 1'h1; // RULE_05
        end else if (load) begin
            next_full = 1'h0; // RULE_04
        end
    end

    // shifter-active flag: drops at completion only if nothing is waiting
    always_comb begin
        next_active = active;
        if (!enabled) begin
            next_active = 1'h0; // RULE_09
        end else if (load) begin
            next_active = 1'h1; // RULE_07
        end else if (link.done && !full && !wr_accept) begin
            next_active = 1'h0; // RULE_07
        end
    end

    // line and completion pulse share one register stage so they stay aligned
    always_comb begin
        next_irq = link.done && enabled; // RULE_13
        next_serial = link.line; // RULE_02
    end

    // state registers; clock enable freezes everything
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            hold <= uart_tx_pkg::BUF_RESET;
            full <= 1'h0;
            active <= 1'h0;
            irq <= 1'h0; // RULE_03
            serial <= uart_tx_pkg::LINE_IDLE;
        end else if (CE_I) begin
            hold <= next_hold;
            full <= next_full;
            active <= next_active;
            irq <= next_irq;
            serial <= next_serial;
        end
    end

    // outputs straight from registers
    always_comb begin
        TX_HOLDING_FULL_FLAG_O = full;
        TX_SHIFTER_ACTIVE_FLAG_O = active;
        TRANSMIT_HOLDING_BUFFER_O = hold;
        TX_DONE_IRQ_O = irq;
        SERIAL_OUT_PIN_O = serial;
    end
endmodule // uart_tx_continuous_control

// ===== logic/uart_tx_pkg.sv
/*
 * Shared constants and types for the transmit-side continuous control block.
 * Assumes a single peripheral clock; baud ticks come from logic on that clock.
 */
package uart_tx_pkg;

    // character and control widths
    localparam int DATA_W = 8;
    localparam int CNT_W = 3;
    localparam int PAR_W = 2;

    // line levels
    localparam logic LINE_IDLE = 1'h1;
    localparam logic START_LEVEL = 1'h0;
    localparam logic STOP_LEVEL = 1'h1;

    // parity selection codes on the parity-mode port
    localparam logic [PAR_W-1:0] PARITY_NONE = 2'h0;
    localparam logic [PAR_W-1:0] PARITY_ZERO = 2'h1;
    localparam logic [PAR_W-1:0] PARITY_ODD = 2'h2;
    localparam logic [PAR_W-1:0] PARITY_EVEN = 2'h3;

    // index of the last data bit for 8-bit and 7-bit characters
    localparam logic [CNT_W-1:0] LAST_BIT_8 = 3'h7;
    localparam logic [CNT_W-1:0] LAST_BIT_7 = 3'h6;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

    // reset values and character masks
    localparam logic [DATA_W-1:0] BUF_RESET = 8'hFF;
    localparam logic [DATA_W-1:0] SHIFT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MASK_7BIT = 8'h7F;
    localparam logic [DATA_W-1:0] MASK_8BIT = 8'hFF;

    // frame sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP
    } frame_state_t;

endpackage

// ===== verif/serial_rx_model.sv
/* remote receiver on the serial line, sampling mid-bit.
   assumes a bit period of BIT clocks and a format steady per frame. */
`timescale 1ns/100ps
module serial_rx_model #(parameter int BIT = 8) (
    // clock, line, format
    input wire logic clk,
    input wire logic line,
    input wire logic data8,
    input wire logic [1:0] par,
    // byte, error, one-cycle strobe
    output logic [7:0] q,
    output logic err,
    output logic vld
);
    // only the first stop bit is judged, a second one reads as idle
    initial begin
        q = 8'h00;
        err = 1'b0;
        vld = 1'b0;
        forever begin
            @(negedge line);
            repeat (BIT / 2) @(posedge clk);
            err = line;
            q = 8'h00;
            for (int i = 0; i < (data8 ? 8 : 7); i++) begin
                repeat (BIT) @(posedge clk);
                q[i] = line;
            end
            if (par != 2'h0) begin
                repeat (BIT) @(posedge clk);
                err = err | (line !== ((par == 2'h1) ? 1'b0 : (^q ^ (par == 2'h2))));
            end
            repeat (BIT) @(posedge clk);
            err = err | !line;
            vld = 1'b1;
            @(posedge clk);
            vld = 1'b0;
        end
    end
endmodule // serial_rx_model

// ===== verif/test_uart_tx_continuous_control.sv
/* self-checking bench; a receiver model decodes the line.
   assumes a tick every BIT clocks; clock enable high except where s_freeze drops it. */
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_uart_tx_continuous_control;
    localparam int BIT = 8;
    logic clk = 1'b0, rst_n = 1'b0, en_unit = 1'b1, en_tx = 1'b1, data8 = 1'b1;
    logic two_stop = 1'b0, tick = 1'b0, wr = 1'b0, full, active, irq, line, rx_v, rx_e;
    logic ce = 1'b1;
    logic [1:0] par = 2'h0;
    logic [7:0] wr_d = 8'h00, buf_q, rx_b;
    logic [8:0] got[$];
    int tcnt = 0, irqs = 0, act_cyc = 0, errors = 0, checks_done = 0;
    uart_tx_continuous_control DUT (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .SERIAL_UNIT_ENABLE_BIT_I(en_unit), .TX_ENABLE_BIT_I(en_tx), .DATA8_I(data8),
        .PARITY_MODE_I(par), .TWO_STOP_I(two_stop), .BIT_TICK_I(tick), .WR_STROBE_I(wr),
        .WR_DATA_I(wr_d), .TX_HOLDING_FULL_FLAG_O(full), .TX_SHIFTER_ACTIVE_FLAG_O(active),
        .TRANSMIT_HOLDING_BUFFER_O(buf_q), .TX_DONE_IRQ_O(irq), .SERIAL_OUT_PIN_O(line));
    serial_rx_model #(.BIT(BIT)) u_rx (.clk(clk), .line(line), .data8(data8), .par(par),
        .q(rx_b), .err(rx_e), .vld(rx_v));
    // 125 MHz clock
    always #4 clk = ~clk;
    // tick, completion count and busy cycles
    always @(posedge clk) begin
        tcnt <= (tcnt == BIT - 1) ? 0 : tcnt + 1;
        tick <= (tcnt == BIT - 1);
        irqs <= irqs + int'(irq === 1'b1);
        act_cyc <= act_cyc + int'(active === 1'b1);
    end
    // negedge sampling avoids racing the model's strobe
    always @(negedge clk)
        if (rx_v === 1'b1)
            got.push_back({rx_e, rx_b});
    task automatic wr_byte(input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        wr_d <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic wait_sig(input int w, input logic v);
        int k;
        k = 0;
        while (((w == 0) ? full : active) !== v && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        `CHK(((w == 0) ? full : active), v)
    endtask
    task automatic rx_is(input logic [8:0] e);
        logic [8:0] g;
        g = (got.size() > 0) ? got.pop_front() : 9'h1FF;
        `CHK(g, e)
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic s_stream();
        irqs = 0;
        act_cyc = 0;
        `CHK(({full, active}), 2'h0)
        wr_byte(8'h3C);
        `CHK(({full, buf_q}), 9'h13C)
        wait_sig(0, 1'b0);
        `CHK(active, 1'b1)
        wr_byte(8'h96);
        `CHK(({full, active}), 2'h3)
        wait_sig(0, 1'b0);
        wr_byte(8'hE1);
        wait_sig(1, 1'b0);
        repeat (2 * BIT) @(posedge clk);
        `CHK(({irqs == 3, line}), 2'h3)
        `CHK(act_cyc > 29 * BIT - 4 && act_cyc < 29 * BIT + 4, 1'b1)
        rx_is(9'h03C);
        rx_is(9'h096);
        rx_is(9'h0E1);
    endtask
    // every parity code, both stop lengths, both character sizes
    task automatic s_formats();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            // step off the edge so the tally reset cannot race the counter
            #1;
            irqs = 0;
            d = 8'hC3 ^ 8'(i * 37);
            @(posedge clk);
            par <= 2'(i);
            two_stop <= i[0];
            data8 <= ~i[1];
            wr_byte(d);
            wait_sig(1, 1'b1);
            wait_sig(1, 1'b0);
            repeat (2 * BIT) @(posedge clk);
            rx_is({1'b0, i[1] ? (d & uart_tx_pkg::MASK_7BIT) : d});
            `CHK(irqs, 1)
        end
    endtask
    // abort by disable, write while off, then cut a frame by reset
    task automatic s_stop();
        #1;
        irqs = 0;
        wr_byte(8'h5A);
        wait_sig(1, 1'b1);
        repeat (3 * BIT) @(posedge clk);
        en_tx <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(({full, active}), 2'h0)
        @(posedge clk);
        en_unit <= 1'b0;
        en_tx <= 1'b1;
        wr_byte(8'h66);
        `CHK(full, 1'b0)
        @(posedge clk);
        en_unit <= 1'b1;
        wr_byte(8'h81);
        wait_sig(1, 1'b1);
        repeat (5 * BIT) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CHK(({full, active, buf_q, line}), ({2'h0, uart_tx_pkg::BUF_RESET, 1'b1}))
        repeat (15 * BIT) @(posedge clk);
        `CHK(({irqs, line}), ({32'h0, 1'b1}))
    endtask
    // clock enable low freezes flags and buffer; a held byte waits for it
    task automatic s_freeze();
        got.delete();
        @(posedge clk);
        ce <= 1'b0;
        wr <= 1'b1;
        wr_d <= 8'h77;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2 * BIT) @(posedge clk);
        #1;
        `CHK(({full, active, buf_q}), ({2'h0, uart_tx_pkg::BUF_RESET}))
        @(posedge clk);
        ce <= 1'b1;
        wr <= 1'b1;
        wr_d <= 8'h4B;
        // freeze on the very edge after the write so no tick can move the byte
        @(posedge clk);
        ce <= 1'b0;
        wr <= 1'b0;
        repeat (2 * BIT) @(posedge clk);
        #1;
        `CHK(({full, active, buf_q}), 10'h24B)
        @(posedge clk);
        ce <= 1'b1;
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        repeat (2 * BIT) @(posedge clk);
        rx_is(9'h04B);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        s_stream();
        s_formats();
        s_stop();
        s_freeze();
        report_and_stop();
    end
    // watchdog far beyond the ~1000 cycles needed
    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
endmodule // test_uart_tx_continuous_control

// ===== verif/uart_tx_cc_chk.sv
/* port-level checks of the transmit control block, bound at the foot.
   assumes all controls come from logic on CLK_I. */
`timescale 1ns/100ps
module uart_tx_cc_chk (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // controls
    input wire logic CE_I,
    input wire logic SERIAL_UNIT_ENABLE_BIT_I,
    input wire logic TX_ENABLE_BIT_I,
    input wire logic BIT_TICK_I,
    input wire logic WR_STROBE_I,
    input wire logic [uart_tx_pkg::DATA_W-1:0] WR_DATA_I,
    // status and line
    input wire logic TX_HOLDING_FULL_FLAG_O,
    input wire logic TX_SHIFTER_ACTIVE_FLAG_O,
    input wire logic [uart_tx_pkg::DATA_W-1:0] TRANSMIT_HOLDING_BUFFER_O,
    input wire logic TX_DONE_IRQ_O,
    input wire logic SERIAL_OUT_PIN_O
);
    logic en;
    // a write or transfer only counts with both enables and the clock enable
    assign en = CE_I && SERIAL_UNIT_ENABLE_BIT_I && TX_ENABLE_BIT_I;
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    a_irq_one_cycle: assert property (TX_DONE_IRQ_O |=> !TX_DONE_IRQ_O)
        else $error("irq too wide");
    a_irq_stop_high: assert property (TX_DONE_IRQ_O |-> SERIAL_OUT_PIN_O)
        else $error("irq off stop bit");
    a_write_sets_full: assert property (en && WR_STROBE_I |=> TX_HOLDING_FULL_FLAG_O
        && TRANSMIT_HOLDING_BUFFER_O == $past(WR_DATA_I)) else $error("write lost");
    a_full_waits_tick: assert property (en && TX_HOLDING_FULL_FLAG_O && !BIT_TICK_I
        |=> TX_HOLDING_FULL_FLAG_O) else $error("full dropped");
    a_off_clears: assert property (CE_I && !(SERIAL_UNIT_ENABLE_BIT_I && TX_ENABLE_BIT_I)
        |=> !TX_HOLDING_FULL_FLAG_O && !TX_SHIFTER_ACTIVE_FLAG_O) else $error("flags kept");
    a_off_line_idle: assert property ((CE_I && !en) [*3]
        |-> SERIAL_OUT_PIN_O && !TX_DONE_IRQ_O) else $error("abort not idle");
    a_start_on_tick: assert property ($rose(TX_SHIFTER_ACTIVE_FLAG_O)
        |-> $past(BIT_TICK_I) || $past(BIT_TICK_I, 2)) else $error("start off tick");
    a_end_with_irq: assert property ($fell(TX_SHIFTER_ACTIVE_FLAG_O)
        |-> TX_DONE_IRQ_O || !$past(en)) else $error("active fell early");
endmodule // uart_tx_cc_chk
bind uart_tx_continuous_control uart_tx_cc_chk u_chk (.CLK_I, .RST_N_I, .CE_I,
    .SERIAL_UNIT_ENABLE_BIT_I, .TX_ENABLE_BIT_I, .BIT_TICK_I, .WR_STROBE_I, .WR_DATA_I,
    .TX_HOLDING_FULL_FLAG_O, .TX_SHIFTER_ACTIVE_FLAG_O, .TRANSMIT_HOLDING_BUFFER_O,
    .TX_DONE_IRQ_O, .SERIAL_OUT_PIN_O);
